// ### src/xfer_port_pkg.sv
package xfer_port_pkg;

   // ==================================================
   // Widths and buffer depth
   localparam int PORT_W = 16;
   localparam int COUNT_W = 16;
   localparam int BUF_DEPTH = 2;

   // ==================================================
   // Pin levels after reset
   localparam logic RST_REQUEST_N = 1'h1;
   localparam logic RST_LOAD_N = 1'h1;
   localparam logic RST_DIRECTION = 1'h1;
   localparam logic RST_CHANNEL = 1'h0;
   localparam logic RST_DATA_OE_N = 1'h1;
   localparam logic RST_EOP_OE_N = 1'h1;

   // ==================================================
   // Direction encoding on the pin
   localparam logic DIR_TO_BOARD = 1'h1;
   localparam logic DIR_TO_EISA = 1'h0;

   // ==================================================
   // Link clock, nominal 16 to 20 MHz
   localparam int PORT_CLK_MIN_KHZ = 16000;
   localparam int PORT_CLK_MAX_KHZ = 20000;

   // ==================================================
   // Sequencer states
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_LOAD = 4'h2,
      ST_XFER = 4'h4,
      ST_EOP = 4'h8
   } port_state_t;

endpackage

// ### src/transfer_buffer_port.sv
`timescale 1ns/1ps

// Summary of operation
// (RQ1) Request output goes low when the port wants to move data.
// (RQ2) Request stays low until transfer completes or is interrupted.
// (RQ3) Buffer logic acknowledges each 16-bit word once.
// (RQ4) Address-load output loads start and real-time address into external counter; the code loads only the start address, once per transfer.
// (RQ5) Address-load asserted at each new channel access, held until acknowledged.
// (RQ6) Direction high means EISA to board, low means board to EISA.
// (RQ7) Direction valid with load or request, stable while request is low.
// (RQ8) Channel select low for channel 0, high for channel 1.
// (RQ9) Channel select times like direction, stable while load or request low.
// (RQ10) Port data bus carries word-aligned 16-bit data.
// (RQ11) Transfer address is driven on the data bus during address load.
// (RQ12) Data bus never driven while external output-enable input is high; the code releases the bus up to three clk_i cycles after the input rises.
// (RQ13) During EISA write transfers the data lines are inputs only.
// (RQ14) End-of-process pulled low at transfer end, released otherwise.
// (RQ15) All port control is synchronous to the port clock; the code moves direction, channel and bus enable on clk_i alone.
// (RQ16) Reset: request and load high, direction high, channel low, bus released.
// (RQ17) Acknowledge sampled on port clock rising edges, one word per asserted edge.
module transfer_buffer_port
   import xfer_port_pkg::*;
#(
   parameter int DATA_W = PORT_W,
   parameter int CNT_W = COUNT_W,
   parameter int DEPTH = BUF_DEPTH
) (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic start_i,
   input wire logic start_direction_i,
   input wire logic start_channel_i,
   input wire logic [DATA_W-1:0] start_addr_i,
   input wire logic [CNT_W-1:0] start_words_i,
   input wire logic abort_i,
   input wire logic [DATA_W-1:0] tx_data_i,
   input wire logic tx_valid_i,
   output logic tx_ready_o,
   output logic [DATA_W-1:0] rx_data_o,
   output logic rx_valid_o,
   input wire logic rx_ready_i,
   output logic busy_o,
   output logic done_o,
   input wire logic port_clock_i,
   input wire logic xfer_ack_n_i,
   input wire logic data_output_enable_n_i,
   input wire logic [DATA_W-1:0] port_data_bus_i,
   output logic [DATA_W-1:0] port_data_bus_o,
   output logic port_data_bus_oe_n_o,
   output logic xfer_request_n_o,
   output logic addr_load_n_o,
   output logic xfer_direction_o,
   output logic channel_select_o,
   output logic end_of_process_n_o,
   output logic end_of_process_oe_n_o
);

   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL = CW'(DEPTH);
   localparam logic [PW-1:0] LAST_SLOT = PW'(DEPTH - 1);

   // ==================================================
   // State
   typedef struct packed {
      port_state_t st;
      logic clk_s0;
      logic clk_s1;
      logic clk_prev;
      logic ack_s0;
      logic ack_s1;
      logic oe_s0;
      logic oe_s1;
      logic [DATA_W-1:0] dat_s0;
      logic [DATA_W-1:0] dat_s1;
      logic req_n;
      logic load_n;
      logic dir;
      logic chan;
      logic [DATA_W-1:0] dout;
      logic dout_oe_n;
      logic eop_oe_n;
      logic [DATA_W-1:0] addr;
      logic [CNT_W-1:0] left;
      logic [DEPTH-1:0][DATA_W-1:0] mem;
      logic [PW-1:0] wp;
      logic [PW-1:0] rp;
      logic [CW-1:0] cnt;
      logic tx_ready;
      logic [DATA_W-1:0] rx_data;
      logic rx_valid;
      logic busy;
      logic done;
   } port_regs_t;

   port_regs_t q;
   port_regs_t next_q;
   logic edge_seen;
   logic acked;
   logic push;
   logic pop;
   logic [DATA_W-1:0] push_data;

   // ==================================================
   // Next state
   always_comb begin
      next_q = q;
      // Two-stage synchronisers for every pin input
      next_q.clk_s0 = port_clock_i;
      next_q.clk_s1 = q.clk_s0;
      next_q.clk_prev = q.clk_s1;
      next_q.ack_s0 = xfer_ack_n_i;
      next_q.ack_s1 = q.ack_s0;
      next_q.oe_s0 = data_output_enable_n_i;
      next_q.oe_s1 = q.oe_s0;
      next_q.dat_s0 = port_data_bus_i;
      next_q.dat_s1 = q.dat_s0;
      next_q.done = 1'h0;

      // Request, load, bus data and end-of-process pins move only on a port clock rising edge
      edge_seen = q.clk_s1 & ~q.clk_prev; // [RQ15]
      acked = edge_seen && (q.st == ST_XFER) && !q.req_n && !q.ack_s1; // [RQ17] [RQ3]

      push = 1'h0;
      pop = 1'h0;
      push_data = tx_data_i;
      if (q.dir == DIR_TO_BOARD) begin
         push = tx_valid_i && q.tx_ready;
         pop = acked;
      end else begin
         push = acked;
         push_data = q.dat_s1; // [RQ10]
         pop = q.rx_valid && rx_ready_i;
      end

      case (q.st)
         ST_IDLE: begin
            if (start_i && (start_words_i != '0)) begin
               // Latched while load and request are both inactive
               next_q.dir = start_direction_i; // [RQ6] [RQ7]
               next_q.chan = start_channel_i; // [RQ8] [RQ9]
               next_q.addr = start_addr_i;
               next_q.left = start_words_i;
               next_q.busy = 1'h1;
               next_q.st = ST_LOAD;
            end
         end
         ST_LOAD: begin
            if (abort_i && edge_seen) begin
               next_q.load_n = 1'h1;
               next_q.busy = 1'h0;
               next_q.st = ST_IDLE;
            end else if (edge_seen && q.load_n) begin
               next_q.load_n = 1'h0; // [RQ4] [RQ5]
               next_q.dout = q.addr; // [RQ11]
            end else if (edge_seen && !q.ack_s1) begin
               // Held until the buffer logic answers it
               next_q.load_n = 1'h1; // [RQ5]
               next_q.st = ST_XFER;
            end
         end
         ST_XFER: begin
            if (abort_i && edge_seen) begin
               next_q.req_n = 1'h1; // [RQ2]
               next_q.busy = 1'h0;
               next_q.st = ST_IDLE;
            end else if (acked && (q.left == CNT_W'(1))) begin
               next_q.left = '0;
               next_q.req_n = 1'h1; // [RQ2]
               next_q.eop_oe_n = 1'h0; // [RQ14]
               next_q.st = ST_EOP;
            end else if (acked) begin
               next_q.left = q.left - 1'h1; // [RQ17]
            end
         end
         ST_EOP: begin
            if (edge_seen) begin
               next_q.eop_oe_n = 1'h1; // [RQ14]
            end
            // Received words still waiting for the user keep the port busy,
            // since dropping back to idle would flush them.
            if (next_q.eop_oe_n && ((q.dir == DIR_TO_BOARD) || (q.cnt == '0))) begin
               next_q.busy = 1'h0;
               next_q.done = 1'h1;
               next_q.st = ST_IDLE;
            end
         end
         default: begin
            next_q.st = ST_IDLE;
         end
      endcase

      // Two-entry buffer
      if (push) begin
         next_q.mem[q.wp] = push_data;
         next_q.wp = (q.wp == LAST_SLOT) ? '0 : q.wp + 1'h1;
      end
      if (pop) begin
         next_q.rp = (q.rp == LAST_SLOT) ? '0 : q.rp + 1'h1;
      end
      if (push && !pop) begin
         next_q.cnt = q.cnt + 1'h1;
      end else if (pop && !push) begin
         next_q.cnt = q.cnt - 1'h1;
      end
      if (next_q.st == ST_IDLE) begin
         // Abort drops any words still held
         next_q.wp = '0;
         next_q.rp = '0;
         next_q.cnt = '0;
      end

      // Request tracks buffer fill (a word to send, or room to receive); a stall here is an interruption,
      // resumed later without a new address load.
      if ((q.st == ST_XFER) && (next_q.st == ST_XFER) && edge_seen) begin
         if (q.dir == DIR_TO_BOARD) begin
            next_q.req_n = (next_q.cnt == '0); // [RQ1]
         end else begin
            next_q.req_n = (next_q.cnt == FULL); // [RQ1]
         end
         if (q.dir == DIR_TO_BOARD) begin
            next_q.dout = next_q.mem[next_q.rp];
         end
      end

      // Bus drive re-evaluated every clk_i cycle so the synchronised external enable acts without waiting for a port clock edge
      if (q.oe_s1) begin
         next_q.dout_oe_n = 1'h1; // [RQ12]
      end else if ((next_q.st == ST_LOAD) && !next_q.load_n) begin
         next_q.dout_oe_n = 1'h0; // [RQ11]
      end else if ((next_q.st == ST_XFER) && (next_q.dir == DIR_TO_BOARD) && !next_q.req_n) begin
         next_q.dout_oe_n = 1'h0;
      end else begin
         next_q.dout_oe_n = 1'h1; // [RQ13]
      end

      next_q.tx_ready = next_q.busy && (next_q.dir == DIR_TO_BOARD) && (next_q.cnt != FULL);
      next_q.rx_valid = (next_q.dir == DIR_TO_EISA) && (next_q.cnt != '0);
      next_q.rx_data = next_q.mem[next_q.rp];
   end

   // ==================================================
   // Registers
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         q <= '0;
         q.st <= ST_IDLE;
         q.clk_s0 <= 1'h1;
         q.clk_s1 <= 1'h1;
         q.clk_prev <= 1'h1;
         q.ack_s0 <= 1'h1;
         q.ack_s1 <= 1'h1;
         q.oe_s0 <= 1'h1;
         q.oe_s1 <= 1'h1;
         q.req_n <= RST_REQUEST_N; // [RQ16]
         q.load_n <= RST_LOAD_N; // [RQ16]
         q.dir <= RST_DIRECTION; // [RQ16]
         q.chan <= RST_CHANNEL; // [RQ16]
         q.dout_oe_n <= RST_DATA_OE_N; // [RQ16]
         q.eop_oe_n <= RST_EOP_OE_N;
      end else begin
         q <= next_q;
      end
   end

   // ==================================================
   // Outputs
   assign tx_ready_o = q.tx_ready;
   assign rx_data_o = q.rx_data;
   assign rx_valid_o = q.rx_valid;
   assign busy_o = q.busy;
   assign done_o = q.done;
   assign port_data_bus_o = q.dout;
   assign port_data_bus_oe_n_o = q.dout_oe_n;
   assign xfer_request_n_o = q.req_n;
   assign addr_load_n_o = q.load_n;
   assign xfer_direction_o = q.dir;
   assign channel_select_o = q.chan;
   // Open collector: only ever pulls low
   assign end_of_process_n_o = 1'h0; // [RQ14]
   assign end_of_process_oe_n_o = q.eop_oe_n;

   // ==================================================
   // Checks
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (srst_i);

   a_reset_levels: assert property ( // [RQ16]
      $fell(srst_i) |-> xfer_request_n_o && addr_load_n_o && xfer_direction_o
         && !channel_select_o && port_data_bus_oe_n_o && end_of_process_oe_n_o)
      else $error("pin levels wrong after reset");

   a_dir_stable: assert property ( // [RQ7]
      (!xfer_request_n_o || !addr_load_n_o) && $past(!xfer_request_n_o || !addr_load_n_o)
         |-> $stable(xfer_direction_o))
      else $error("direction changed during load or request");

   a_chan_stable: assert property ( // [RQ9]
      (!xfer_request_n_o || !addr_load_n_o) ##1 (!xfer_request_n_o || !addr_load_n_o)
         |-> $stable(channel_select_o))
      else $error("channel select changed during load or request");

   a_load_held: assert property ( // [RQ5]
      !addr_load_n_o && !(edge_seen && !q.ack_s1) && !abort_i |=> !addr_load_n_o)
      else $error("address load released before acknowledge");

   a_oe_blocks: assert property ( // [RQ12]
      q.oe_s1 |=> port_data_bus_oe_n_o)
      else $error("bus driven while output enable input high");

   a_write_input: assert property ( // [RQ13]
      (xfer_direction_o == DIR_TO_EISA) && !xfer_request_n_o |-> port_data_bus_oe_n_o)
      else $error("bus driven during EISA write");

   a_addr_on_bus: assert property ( // [RQ11]
      !addr_load_n_o && !port_data_bus_oe_n_o |-> port_data_bus_o == q.addr)
      else $error("address missing on bus during load");

   a_eop_short: assert property ( // [RQ14]
      $fell(end_of_process_oe_n_o) |-> ##[1:80] end_of_process_oe_n_o)
      else $error("end of process held too long");

   a_req_only_xfer: assert property ( // [RQ1]
      !xfer_request_n_o |-> q.st == ST_XFER && addr_load_n_o)
      else $error("request outside transfer phase");

   a_ack_advance: assert property ( // [RQ17]
      acked && (q.left > CNT_W'(1)) && !abort_i |=> q.left == $past(q.left) - 1'h1)
      else $error("acknowledged word not counted");

   a_drain_first: assert property ( // [RQ2]
      (q.st == ST_EOP) && (q.dir == DIR_TO_EISA) && (q.cnt != '0) |=> !done_o)
      else $error("done reported before received words were taken");

   c_to_board_done: cover property (
      q.st == ST_EOP && q.dir == DIR_TO_BOARD ##[1:80] done_o);
   c_to_eisa_done: cover property (
      q.st == ST_EOP && q.dir == DIR_TO_EISA ##[1:80] done_o);
   c_aborted: cover property (q.st == ST_XFER && abort_i ##[1:40] q.st == ST_IDLE);
   c_buffer_stall: cover property (q.st == ST_XFER && q.cnt == FULL && q.dir == DIR_TO_EISA);

endmodule

// ### dv/xfer_buffer_model.sv
`timescale 1ns/1ps
// ==========
// Board-side buffer logic with address capture
module xfer_buffer_model
   import xfer_port_pkg::*;
(
   input wire logic port_clock_i,
   input wire logic slow_i,
   input wire logic request_n_i,
   input wire logic load_n_i,
   input wire logic direction_i,
   input wire logic [PORT_W-1:0] bus_i,
   input wire logic eop_i,
   output logic ack_n_o,
   output logic drive_o,
   output logic [PORT_W-1:0] data_o
);
   logic [PORT_W-1:0] got_q[$];
   logic [PORT_W-1:0] addr_seen = 16'h0000;
   logic moved = 1'h0;
   logic skip = 1'h0;
   int eop_count = 0;
   initial begin
      ack_n_o = 1'h1;
      drive_o = 1'h0;
      data_o = 16'h3C00;
   end
   // Taken at the rising edge where our ack is sampled
   always @(posedge port_clock_i) begin
      moved <= !ack_n_o && !request_n_i && direction_i == DIR_TO_EISA;
      if (!ack_n_o && !load_n_i) addr_seen <= bus_i;
      if (!ack_n_o && !request_n_i && direction_i == DIR_TO_BOARD) got_q.push_back(bus_i);
      if (!eop_i) eop_count <= eop_count + 1;
   end
   // Half a period later, so no word moves near a sampling edge
   always @(negedge port_clock_i) begin
      if (moved) data_o <= data_o + 16'h1;
      skip <= slow_i && !skip;
      ack_n_o <= !((!load_n_i || !request_n_i) && !skip);
      drive_o <= !request_n_i && direction_i == DIR_TO_EISA;
   end
endmodule

// ### dv/transfer_buffer_port_tb.sv
`timescale 1ns/1ps
module transfer_buffer_port_tb;
   import xfer_port_pkg::*;
   typedef struct packed {
      logic dir;
      logic chan;
      logic [15:0] addr;
      logic [15:0] words;
      logic slow;
      logic stall;
      logic exp_dir;
      logic exp_chan;
   } row_t;
   // ==========
   // Ordinary transfers
   localparam row_t ROWS [4] = '{
      '{1'h1, 1'h0, 16'h0000, 16'h0001, 1'h0, 1'h0, DIR_TO_BOARD, 1'h0},
      '{1'h0, 1'h1, 16'hFFFE, 16'h0003, 1'h1, 1'h0, DIR_TO_EISA, 1'h1},
      '{1'h1, 1'h1, 16'h1234, 16'h0005, 1'h1, 1'h1, DIR_TO_BOARD, 1'h1},
      '{1'h0, 1'h0, 16'h8000, 16'h0006, 1'h0, 1'h1, DIR_TO_EISA, 1'h0}
   };
   logic clk_i = 1'h0, srst_i = 1'h1, port_clock_i = 1'h1, abort_i = 1'h0;
   logic start_i = 1'h0, start_direction_i = 1'h0, start_channel_i = 1'h0;
   logic tx_valid_i = 1'h0, rx_ready_i = 1'h1, data_output_enable_n_i = 1'h0;
   logic [15:0] start_addr_i = 16'h0000, start_words_i = 16'h0000, tx_data_i = 16'h0000;
   logic tx_rdy, rx_vld, busy_o, done_o, oe_n, req_n, load_n, dir, chan, eop_n, eop_oe_n;
   logic ack_n, p_drive, feed = 1'h0, stall = 1'h0, watch = 1'h0;
   logic [15:0] rx_data, data_o, p_data, idle_q = 16'h0000, tx_next = 16'h0000, tx_end;
   logic [15:0] rx_q[$];
   wire logic [15:0] bus_w = (oe_n === 1'h0) ? data_o : (p_drive ? p_data : ~idle_q);
   wire logic eop_w = eop_oe_n ? 1'h1 : eop_n;
   row_t cur;
   int err_count = 0, n_compared = 0, en_hi = 0, cyc = 0;

   transfer_buffer_port u_transfer_buffer_port (.clk_i, .srst_i, .start_i, .start_direction_i,
      .start_channel_i, .start_addr_i, .start_words_i, .abort_i, .tx_data_i, .tx_valid_i,
      .tx_ready_o(tx_rdy), .rx_data_o(rx_data), .rx_valid_o(rx_vld), .rx_ready_i, .busy_o,
      .done_o, .port_clock_i, .xfer_ack_n_i(ack_n), .data_output_enable_n_i,
      .port_data_bus_i(bus_w), .port_data_bus_o(data_o), .port_data_bus_oe_n_o(oe_n),
      .xfer_request_n_o(req_n), .addr_load_n_o(load_n), .xfer_direction_o(dir),
      .channel_select_o(chan), .end_of_process_n_o(eop_n), .end_of_process_oe_n_o(eop_oe_n));
   xfer_buffer_model u_xfer_buffer_model (.port_clock_i, .slow_i(cur.slow), .request_n_i(req_n),
      .load_n_i(load_n), .direction_i(dir), .bus_i(bus_w), .eop_i(eop_w), .ack_n_o(ack_n),
      .drive_o(p_drive), .data_o(p_data));

   always #2.5 clk_i = ~clk_i;
   initial begin
      #1.3;
      forever #62.5 port_clock_i = ~port_clock_i;
   end
   // ==========
   // User streams, with long stalls so the buffer fills and runs dry
   always @(posedge clk_i) begin
      // Released bus shows the inverse of the last driven word
      if (oe_n === 1'h0 || p_drive === 1'h1) idle_q <= bus_w;
      cyc <= cyc + 1;
      if (rx_vld === 1'h1 && rx_ready_i) rx_q.push_back(rx_data);
      if (tx_valid_i && tx_rdy === 1'h1) tx_next <= tx_next + 16'h1;
   end
   always @(negedge clk_i) begin
      tx_data_i <= tx_next;
      tx_valid_i <= feed && tx_next != tx_end && !(stall && cyc[6]);
      rx_ready_i <= !(stall && cyc[6]);
      en_hi = data_output_enable_n_i ? en_hi + 1 : 0;
      if (en_hi > 6 && oe_n !== 1'h1) begin
         err_count++;
         $display("ERROR bus release expected 1 seen %b", oe_n);
      end
      if (watch && (!req_n || !load_n) && {dir, chan} !== {cur.exp_dir, cur.exp_chan}) begin
         err_count++;
         $display("ERROR dir/chan expected %b%b seen %b%b", cur.exp_dir, cur.exp_chan, dir, chan);
      end
      if (dir === DIR_TO_EISA && req_n === 1'h0 && oe_n !== 1'h1) begin
         err_count++;
         $display("ERROR bus release in read expected 1 seen %b", oe_n);
      end
   end

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic finish_test;
      if (err_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic check_reset_pins;
      check("request", 32'h1, req_n);
      check("load", 32'h1, load_n);
      check("direction", 32'h1, dir);
      check("channel", 32'h0, chan);
      check("bus enable", 32'h1, oe_n);
      check("eop", 32'h1, eop_w);
   endtask
   task automatic start_xfer(input row_t r);
      cur = r;
      stall = r.stall;
      tx_end = tx_next + r.words;
      feed = r.dir;
      {start_direction_i, start_channel_i, start_addr_i, start_words_i} = {r.dir, r.chan, r.addr, r.words};
      start_i = 1'h1;
      @(negedge clk_i);
      start_i = 1'h0;
      watch = 1'h1;
   endtask
   task automatic wait_req;
      for (int k = 0; k < 4000 && req_n !== 1'h0; k++) @(negedge clk_i);
   endtask
   task automatic run_row(input row_t r);
      logic [15:0] base;
      logic [15:0] pbase;
      base = tx_next;
      pbase = p_data;
      u_xfer_buffer_model.got_q.delete();
      u_xfer_buffer_model.addr_seen = ~r.addr;
      u_xfer_buffer_model.eop_count = 0;
      rx_q.delete();
      start_xfer(r);
      for (int k = 0; k < 20000 && done_o !== 1'h1; k++) @(negedge clk_i);
      watch = 1'h0;
      check("done", 32'h1, done_o);
      check("address", r.addr, u_xfer_buffer_model.addr_seen);
      check("eop count", 32'h1, u_xfer_buffer_model.eop_count);
      if (r.dir) check("words out", r.words, u_xfer_buffer_model.got_q.size());
      else check("words in", r.words, rx_q.size());
      for (int i = 0; i < r.words; i++) begin
         if (r.dir && i < u_xfer_buffer_model.got_q.size())
            check("word out", base + i, u_xfer_buffer_model.got_q[i]);
         if (!r.dir && i < rx_q.size()) check("word in", pbase + i, rx_q[i]);
      end
   endtask

   initial begin
      repeat (8) @(negedge clk_i);
      check_reset_pins();
      srst_i = 1'h0;
      foreach (ROWS[i]) run_row(ROWS[i]);
      // ==========
      // Zero-length start leaves the port idle
      cur = ROWS[0];
      cur.words = 16'h0000;
      start_xfer(cur);
      repeat (2) @(negedge clk_i);
      check("busy on empty start", 32'h0, busy_o);
      // ==========
      // Abort while the bus is lent out
      data_output_enable_n_i = 1'h1;
      u_xfer_buffer_model.eop_count = 0;
      cur = ROWS[2];
      cur.words = 16'h0008;
      start_xfer(cur);
      wait_req();
      repeat (100) @(negedge clk_i);
      abort_i = 1'h1;
      for (int k = 0; k < 200 && busy_o !== 1'h0; k++) @(negedge clk_i);
      {abort_i, feed, watch, data_output_enable_n_i} = 4'h0;
      check("request after abort", 32'h1, req_n);
      check("eop after abort", 32'h0, u_xfer_buffer_model.eop_count);
      // ==========
      // Reset in mid-transfer
      start_xfer(ROWS[3]);
      wait_req();
      watch = 1'h0;
      srst_i = 1'h1;
      repeat (3) @(negedge clk_i);
      check_reset_pins();
      repeat (5) @(negedge clk_i);
      srst_i = 1'h0;
      run_row(ROWS[1]);
      finish_test();
   end
   initial begin
      #400000;
      err_count++;
      finish_test();
   end
endmodule
